// ### logic/esr_pkg.sv
/*
  Shared constants of the edge clocked shift register: word geometry and
  reset values. Assumes nothing beyond a SystemVerilog compiler.
*/
package esr_pkg;
  localparam int WORD_W = 16;
  localparam int NUM_WORDS = 8;
  localparam int IDX_W = 3;
  localparam int BIT_W = 4;
  localparam int ADDR_W = IDX_W + BIT_W;
  localparam int REG_W = WORD_W * NUM_WORDS;
  localparam logic PREV_RST = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
endpackage

// ### logic/esr_word_cell.sv
/*
  One 16-bit word of the shift register: clear, shift-in from the word
  below, and a single-bit write that wins over both. Assumes the caller
  gates clear and shift with the execution strobe and the word range.
*/
`timescale 1ns/1ns
module esr_word_cell (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Word control
  input wire logic clr,
  input wire logic shift,
  input wire logic carry_in,
  // Bit write
  input wire logic wr_en,
  input wire logic [esr_pkg::BIT_W-1:0] wr_bit,
  input wire logic wr_val,
  // Word contents
  output logic [esr_pkg::WORD_W-1:0] q_ff
);
  logic [esr_pkg::WORD_W-1:0] nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (clr) begin
      nxt_q = esr_pkg::WORD_RST;
    end else if (shift) begin
      nxt_q = {q_ff[esr_pkg::WORD_W-2:0], carry_in};
    end
    // A bit written by other logic lands as issued, after any shift.
    if (wr_en) begin
      nxt_q[wr_bit] = wr_val;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q_ff <= esr_pkg::WORD_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule

// ### logic/esr_shift_reg.sv
/*
  Multi-word serial-in shift register evaluated once per execution
  strobe. Assumes all inputs come from logic on the same clock, and that
  the start word is not above the end word.
*/
`timescale 1ns/1ns
module esr_shift_reg (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Execution inputs
  input wire logic exec_strobe,
  input wire logic data_in,
  input wire logic shift_pulse,
  input wire logic clear_in,
  // Register span
  input wire logic [esr_pkg::IDX_W-1:0] low_end_word,
  input wire logic [esr_pkg::IDX_W-1:0] high_end_word,
  // Single-bit write from other logic
  input wire logic bit_wr_en,
  input wire logic [esr_pkg::ADDR_W-1:0] bit_wr_addr,
  input wire logic bit_wr_val,
  // Register contents and stored pulse level
  output logic [esr_pkg::REG_W-1:0] reg_words,
  output logic prev_pulse_ff
);
  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  function automatic logic in_span(
    input logic [esr_pkg::IDX_W-1:0] w,
    input logic [esr_pkg::IDX_W-1:0] lo,
    input logic [esr_pkg::IDX_W-1:0] hi);
    in_span = (w >= lo) && (w <= hi);
  endfunction

  logic nxt_prev_pulse;
  wire do_clear = exec_strobe && clear_in;
  wire do_shift = exec_strobe && shift_pulse && !prev_pulse_ff
    && !clear_in;
  wire [esr_pkg::IDX_W-1:0] wr_word =
    bit_wr_addr[esr_pkg::ADDR_W-1:esr_pkg::BIT_W];
  wire [esr_pkg::BIT_W-1:0] wr_bit = bit_wr_addr[esr_pkg::BIT_W-1:0];
  wire [esr_pkg::REG_W-1:0] span_mask;

  // ---------------------------------------------------------------
  // Word array
  // ---------------------------------------------------------------
  // Words outside the span are never cleared or shifted, so two
  // registers built side by side do not disturb each other.
  for (genvar w = 0; w < esr_pkg::NUM_WORDS; w++) begin : g_word
    localparam logic [esr_pkg::IDX_W-1:0] WI = esr_pkg::IDX_W'(w);
    wire in_w = in_span(WI, low_end_word, high_end_word);
    wire carry;
    if (w == 0) begin : g_first
      assign carry = data_in;
    end else begin : g_rest
      // Above the low end word, bit 15 of the word below crosses into bit 0 here.
      assign carry = (WI == low_end_word) ? data_in
        : reg_words[w*esr_pkg::WORD_W-1];
    end
    assign span_mask[w*esr_pkg::WORD_W +: esr_pkg::WORD_W] =
      {esr_pkg::WORD_W{in_w}};
    esr_word_cell u_cell (
      .clock(clock),
      .srst(srst),
      .clr(do_clear && in_w),
      .shift(do_shift && in_w),
      .carry_in(carry),
      .wr_en(bit_wr_en && (wr_word == WI)),
      .wr_bit(wr_bit),
      .wr_val(bit_wr_val),
      .q_ff(reg_words[w*esr_pkg::WORD_W +: esr_pkg::WORD_W])
    );
  end

  // ---------------------------------------------------------------
  // Edge memory
  // ---------------------------------------------------------------
  // Sampled on every execution, clear or not, so a pulse held high
  // through a clear does not shift on release.
  assign nxt_prev_pulse = exec_strobe ? shift_pulse : prev_pulse_ff;

  always_ff @(posedge clock) begin
    if (srst) begin
      prev_pulse_ff <= esr_pkg::PREV_RST;
    end else begin
      prev_pulse_ff <= nxt_prev_pulse;
    end
  end
  // There are no status flags: no output reports errors; only the checks below do.

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Checks on the new contents index the span sampled with the request,
  // so a span moved right after a shift is not misread as a fault.
  wire [esr_pkg::ADDR_W-1:0] lsb_idx =
    {low_end_word, {esr_pkg::BIT_W{1'b0}}};
  wire [esr_pkg::WORD_W-1:0] low_word =
    reg_words[lsb_idx +: esr_pkg::WORD_W];

  sequence s_rise_clean;
    do_shift && !bit_wr_en;
  endsequence

  sequence s_quiet_exec;
    exec_strobe && !clear_in && !bit_wr_en
      && !(shift_pulse && !prev_pulse_ff);
  endsequence

  sequence s_idle;
    !exec_strobe && !bit_wr_en;
  endsequence

  property p_insert_lsb;
    @(posedge clock) disable iff (srst)
      s_rise_clean |=> reg_words[$past(lsb_idx)] == $past(data_in);
  endproperty
  a_insert_lsb: assert property (p_insert_lsb)
    else $error("data bit not inserted at low end");

  property p_insert_one;
    @(posedge clock) disable iff (srst)
      s_rise_clean ##0 data_in |=> reg_words[$past(lsb_idx)];
  endproperty
  a_insert_one: assert property (p_insert_one)
    else $error("data on did not insert a one");

  property p_move_up;
    @(posedge clock) disable iff (srst)
      s_rise_clean ##0 (low_end_word <= high_end_word)
      |=> reg_words[$past(lsb_idx) + 1 +: 15] == $past(low_word[14:0]);
  endproperty
  a_move_up: assert property (p_move_up)
    else $error("bits did not move up by one");

  property p_cross_word;
    @(posedge clock) disable iff (srst)
      s_rise_clean ##0 (low_end_word < high_end_word)
      |=> reg_words[$past(lsb_idx) + esr_pkg::WORD_W] == $past(low_word[15]);
  endproperty
  a_cross_word: assert property (p_cross_word)
    else $error("top bit of the low word did not cross up");

  property p_hold;
    @(posedge clock) disable iff (srst)
      s_quiet_exec |=> $stable(reg_words);
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed without a rising pulse");

  property p_idle_hold;
    @(posedge clock) disable iff (srst)
      s_idle |=> $stable(reg_words);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("register changed with no execution or write");

  property p_outside_span;
    @(posedge clock) disable iff (srst)
      !bit_wr_en |=> (reg_words & ~$past(span_mask))
        == ($past(reg_words) & ~$past(span_mask));
  endproperty
  a_outside_span: assert property (p_outside_span)
    else $error("word outside the span was altered");

  property p_single_word;
    @(posedge clock) disable iff (srst)
      s_rise_clean ##0 (low_end_word == high_end_word)
      |=> reg_words[$past(lsb_idx) +: esr_pkg::WORD_W]
        == {$past(low_word[14:0]), $past(data_in)};
  endproperty
  a_single_word: assert property (p_single_word)
    else $error("single word register shifted wrongly");

  property p_clear_blocks;
    @(posedge clock) disable iff (srst)
      (do_clear && !bit_wr_en)
      |=> (reg_words & $past(span_mask)) == '0;
  endproperty
  a_clear_blocks: assert property (p_clear_blocks)
    else $error("clear did not hold the span at zero");

  property p_bit_write;
    @(posedge clock) disable iff (srst)
      bit_wr_en |=> reg_words[$past(bit_wr_addr)] == $past(bit_wr_val);
  endproperty
  a_bit_write: assert property (p_bit_write)
    else $error("bit write was not taken");

  property p_edge_memory;
    @(posedge clock) disable iff (srst)
      (exec_strobe && clear_in && shift_pulse) ##1 !exec_strobe
      |=> prev_pulse_ff;
  endproperty
  a_edge_memory: assert property (p_edge_memory)
    else $error("pulse level not kept across clear");

  property p_prev_sample;
    @(posedge clock) disable iff (srst)
      exec_strobe |=> prev_pulse_ff == $past(shift_pulse);
  endproperty
  a_prev_sample: assert property (p_prev_sample)
    else $error("pulse level not stored on execution");

  property p_prev_hold;
    @(posedge clock) disable iff (srst)
      !exec_strobe |=> $stable(prev_pulse_ff);
  endproperty
  a_prev_hold: assert property (p_prev_hold)
    else $error("pulse level changed between executions");
endmodule

// ### bench/edge_clocked_shift_register_tb.sv
/*
  Self-checking bench for the multi-word serial-in shift register.
  Assumes the design package is compiled first; keeps its own model.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module edge_clocked_shift_register_tb;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic exec_strobe = 1'b0;
  logic data_in = 1'b0;
  logic shift_pulse = 1'b0;
  logic clear_in = 1'b0;
  logic [esr_pkg::IDX_W-1:0] low_end_word = 3'h0;
  logic [esr_pkg::IDX_W-1:0] high_end_word = 3'h7;
  logic bit_wr_en = 1'b0;
  logic [esr_pkg::ADDR_W-1:0] bit_wr_addr = 7'h00;
  logic bit_wr_val = 1'b0;
  logic [esr_pkg::REG_W-1:0] reg_words;
  logic prev_pulse_ff;
  logic [esr_pkg::REG_W-1:0] m = '0;
  logic mp = 1'b0;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  always #25 clock = ~clock;
  esr_shift_reg u_esr_shift_reg (.clock(clock), .srst(srst),
    .exec_strobe(exec_strobe), .data_in(data_in),
    .shift_pulse(shift_pulse), .clear_in(clear_in),
    .low_end_word(low_end_word), .high_end_word(high_end_word),
    .bit_wr_en(bit_wr_en), .bit_wr_addr(bit_wr_addr),
    .bit_wr_val(bit_wr_val), .reg_words(reg_words),
    .prev_pulse_ff(prev_pulse_ff));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The whole run is a few hundred cycles; this limit only cuts a hang.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  // Applies one execution to the model over the current span.
  task automatic model(input logic d, input logic p, input logic c);
    int lo;
    int hi;
    lo = 16 * low_end_word;
    hi = 16 * high_end_word + 15;
    if (c) begin
      for (int i = lo; i <= hi; i++) m[i] = 1'b0;
    end else if (p && !mp) begin
      for (int i = hi; i > lo; i--) m[i] = m[i-1];
      m[lo] = d;
    end
    mp = p;
  endtask
  task automatic step(input logic d, input logic p, input logic c);
    @(negedge clock);
    exec_strobe = 1'b1;
    data_in = d;
    shift_pulse = p;
    clear_in = c;
    @(negedge clock);
    exec_strobe = 1'b0;
    model(d, p, c);
    `CHK(reg_words, m)
    `CHK(prev_pulse_ff, mp)
  endtask
  task automatic pulse(input logic d);
    step(d, 1'b0, 1'b0);
    step(d, 1'b1, 1'b0);
  endtask
  task automatic wr_bit(input logic [6:0] a, input logic v);
    @(negedge clock);
    bit_wr_en = 1'b1;
    bit_wr_addr = a;
    bit_wr_val = v;
    @(negedge clock);
    bit_wr_en = 1'b0;
    m[a] = v;
    `CHK(reg_words, m)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_multi();
    wr_bit(7'h0F, 1'b1);
    wr_bit(7'h30, 1'b1);
    low_end_word = 3'h1;
    high_end_word = 3'h2;
    for (int k = 0; k < 34; k++) pulse((k % 3) == 0);
  endtask
  task automatic t_hold();
    step(1'b1, 1'b1, 1'b0);
    step(1'b1, 1'b0, 1'b0);
    step(1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_single();
    low_end_word = 3'h5;
    high_end_word = 3'h5;
    for (int k = 0; k < 18; k++) pulse(k[0]);
  endtask
  task automatic t_clear();
    low_end_word = 3'h2;
    high_end_word = 3'h6;
    pulse(1'b1);
    pulse(1'b1);
    step(1'b1, 1'b0, 1'b0);
    step(1'b1, 1'b1, 1'b1);
    step(1'b1, 1'b1, 1'b0);
    pulse(1'b1);
  endtask
  task automatic t_bitwr();
    low_end_word = 3'h0;
    high_end_word = 3'h1;
    wr_bit(7'h13, 1'b1);
    pulse(1'b0);
  endtask
  // Executions back to back, a write on the bit being shifted into,
  // and a pulse that dips only between executions.
  task automatic t_burst();
    low_end_word = 3'h3;
    high_end_word = 3'h4;
    @(negedge clock);
    exec_strobe = 1'b1;
    data_in = 1'b1;
    shift_pulse = 1'b0;
    clear_in = 1'b0;
    @(negedge clock);
    model(1'b1, 1'b0, 1'b0);
    `CHK(reg_words, m)
    shift_pulse = 1'b1;
    bit_wr_en = 1'b1;
    bit_wr_addr = 7'h30;
    bit_wr_val = 1'b0;
    @(negedge clock);
    bit_wr_en = 1'b0;
    model(1'b1, 1'b1, 1'b0);
    m[7'h30] = 1'b0;
    `CHK(reg_words, m)
    `CHK(prev_pulse_ff, mp)
    @(negedge clock);
    exec_strobe = 1'b0;
    shift_pulse = 1'b0;
    model(1'b1, 1'b1, 1'b0);
    `CHK(reg_words, m)
    @(negedge clock);
    exec_strobe = 1'b1;
    shift_pulse = 1'b1;
    @(negedge clock);
    exec_strobe = 1'b0;
    model(1'b1, 1'b1, 1'b0);
    `CHK(reg_words, m)
    `CHK(prev_pulse_ff, mp)
  endtask
  initial begin
    repeat (6) @(posedge clock);
    @(negedge clock);
    srst = 1'b0;
    `CHK(reg_words, {esr_pkg::REG_W{1'b0}})
    `CHK(prev_pulse_ff, esr_pkg::PREV_RST)
    t_multi();
    t_hold();
    t_single();
    t_clear();
    t_bitwr();
    t_burst();
    wrap_up();
  end
endmodule
